// file: src/emb_defines.svh
// Constants for the external memory bus interface
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
`define EMB_ADDR_W 16
`define EMB_DATA_W 16
`define EMB_CTL_W 8
// Control input vector bit positions
`define EMB_CTL_HOLD 7
`define EMB_CTL_OFF 6
`define EMB_CTL_RS 5
`define EMB_CTL_BR 4
`define EMB_CTL_IAQ 3
`define EMB_CTL_READY 2
`define EMB_CTL_BUS_CYCLE_STROBE_N 1
`define EMB_CTL_RW 0
// Reset values
`define EMB_CTL_RST 8'hfb
`define EMB_ADDR_RST 16'h0000
`define EMB_DATA_RST 16'h0000
`define EMB_SEL_IDLE 1'b1
// Cycles waited before ready is sampled again
`define EMB_READY_RECHECK 1
`endif

// file: src/emb_pkg.sv
// Types for the external memory bus interface
package emb_pkg;
   typedef enum logic [1:0] {
      EMB_SP_DATA = 2'h0,
      EMB_SP_PROG = 2'h1,
      EMB_SP_IO = 2'h2
   } emb_space_t;
   typedef enum logic [2:0] {
      EMB_ST_IDLE = 3'h0,
      EMB_ST_ADDR = 3'h1,
      EMB_ST_BUS_CYCLE_STROBE_N = 3'h2,
      EMB_ST_END = 3'h3,
      EMB_ST_HOLD = 3'h4
   } emb_state_t;
endpackage

// file: src/emb_sync.sv
// Two flip-flop synchroniser for pin inputs
module emb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// file: src/emb_bus_if.sv
// External parallel bus interface with hold and DMA to on-chip RAM
`include "emb_defines.svh"

module emb_bus_if (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Core request port
   input wire logic core_req,
   input wire logic core_write,
   input wire emb_pkg::emb_space_t core_space,
   input wire logic [`EMB_ADDR_W-1:0] core_addr,
   input wire logic [`EMB_DATA_W-1:0] core_wdata,
   output logic core_done,
   output logic [`EMB_DATA_W-1:0] core_rdata,
   // Address bus pins
   input wire logic [`EMB_ADDR_W-1:0] ext_addr_bus_in,
   output logic [`EMB_ADDR_W-1:0] ext_addr_bus_out,
   output logic ext_addr_bus_oe,
   // Data bus pins
   input wire logic [`EMB_DATA_W-1:0] ext_data_bus_in,
   output logic [`EMB_DATA_W-1:0] ext_data_bus_out,
   output logic ext_data_bus_oe,
   // Space select pins
   output logic data_space_sel_n,
   output logic program_space_sel_n,
   output logic io_space_sel_n,
   output logic space_sel_oe,
   // Strobe, direction and read select pins
   input wire logic bus_cycle_strobe_n_in,
   output logic bus_cycle_strobe_n_out,
   output logic bus_cycle_strobe_n_oe,
   input wire logic rd_wr_n_in,
   output logic rd_wr_n_out,
   output logic rd_wr_n_oe,
   output logic read_sel_n,
   output logic read_sel_oe,
   // Hold, request and status pins
   input wire logic bus_ready,
   input wire logic hold_req_n,
   output logic bus_hold_ack_n,
   output logic bus_hold_ack_oe,
   input wire logic bus_request_n,
   input wire logic instr_acquire_n,
   input wire logic output_off_n,
   input wire logic reset_in_n,
   output logic dma_grant,
   // On-chip RAM access port
   output logic dma_ram_en,
   output logic dma_ram_we,
   output logic [`EMB_ADDR_W-1:0] dma_ram_addr,
   output logic [`EMB_DATA_W-1:0] dma_ram_wdata,
   input wire logic [`EMB_DATA_W-1:0] dma_ram_rdata
);
   logic rst_meta_q;
   logic rst_q;
   logic [`EMB_CTL_W-1:0] ctl_s;
   logic [`EMB_ADDR_W-1:0] addr_in_s;
   logic [`EMB_DATA_W-1:0] data_in_s;
   emb_pkg::emb_state_t state_q;
   emb_pkg::emb_state_t state_d;
   logic wr_q;
   emb_pkg::emb_space_t space_q;
   logic [`EMB_ADDR_W-1:0] addr_q;
   logic [`EMB_DATA_W-1:0] wdata_q;
   logic bus_cycle_strobe_n_prev_q;
   logic dma_rd_q;

   // Reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q <= rst_meta_q;
      end
   end

   // Pin synchronisers
   emb_sync #(.W(`EMB_CTL_W), .RST_VAL(`EMB_CTL_RST)) u_sync_ctl (
      .clk(clk),
      .rst_n(rst_q),
      .d({hold_req_n, output_off_n, reset_in_n, bus_request_n,
          instr_acquire_n, bus_ready, bus_cycle_strobe_n_in, rd_wr_n_in}),
      .q(ctl_s)
   );
   emb_sync #(.W(`EMB_ADDR_W), .RST_VAL(`EMB_ADDR_RST)) u_sync_addr (
      .clk(clk),
      .rst_n(rst_q),
      .d(ext_addr_bus_in),
      .q(addr_in_s)
   );
   emb_sync #(.W(`EMB_DATA_W), .RST_VAL(`EMB_DATA_RST)) u_sync_data (
      .clk(clk),
      .rst_n(rst_q),
      .d(ext_data_bus_in),
      .q(data_in_s)
   );

   // Decoded pin levels
   wire hold_s = ctl_s[`EMB_CTL_HOLD];
   wire off_s = ctl_s[`EMB_CTL_OFF];
   wire rs_s = ctl_s[`EMB_CTL_RS];
   wire br_s = ctl_s[`EMB_CTL_BR];
   wire iaq_s = ctl_s[`EMB_CTL_IAQ];
   wire ready_s = ctl_s[`EMB_CTL_READY];
   wire bus_cycle_strobe_n_in_s = ctl_s[`EMB_CTL_BUS_CYCLE_STROBE_N];
   wire rw_in_s = ctl_s[`EMB_CTL_RW];
   wire in_hold = (state_q == emb_pkg::EMB_ST_HOLD);
   wire float_w = in_hold || !off_s;
   wire in_cycle = (state_q == emb_pkg::EMB_ST_BUS_CYCLE_STROBE_N);
   wire dma_mode = in_hold && !br_s && !iaq_s;
   wire dma_bus_cycle_strobe_n = dma_mode && !bus_cycle_strobe_n_in_s && bus_cycle_strobe_n_prev_q;
   wire dma_rd_w = dma_mode && !bus_cycle_strobe_n_in_s && rw_in_s;
   wire take_req = core_req && hold_s && rs_s && off_s;
   wire drive_addr = !float_w && (state_q != emb_pkg::EMB_ST_IDLE);
   wire drive_data = (!float_w && rs_s && hold_s && wr_q &&
                      (state_q != emb_pkg::EMB_ST_IDLE)) ||
                     (dma_rd_q && off_s && rs_s);
   wire sel_act = (state_q == emb_pkg::EMB_ST_ADDR) || in_cycle;

   // Bus cycle sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         emb_pkg::EMB_ST_IDLE: begin
            if (!hold_s) begin
               state_d = emb_pkg::EMB_ST_HOLD;
            end else if (take_req) begin
               state_d = emb_pkg::EMB_ST_ADDR;
            end
         end
         emb_pkg::EMB_ST_ADDR: begin
            state_d = emb_pkg::EMB_ST_BUS_CYCLE_STROBE_N;
         end
         emb_pkg::EMB_ST_BUS_CYCLE_STROBE_N: begin
            if (ready_s) begin
               state_d = emb_pkg::EMB_ST_END;
            end
         end
         emb_pkg::EMB_ST_END: begin
            state_d = emb_pkg::EMB_ST_IDLE;
         end
         emb_pkg::EMB_ST_HOLD: begin
            if (hold_s) begin
               state_d = emb_pkg::EMB_ST_IDLE;
            end
         end
         default: begin
            state_d = emb_pkg::EMB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         state_q <= emb_pkg::EMB_ST_IDLE;
         wr_q <= 1'b0;
         space_q <= emb_pkg::EMB_SP_DATA;
         addr_q <= `EMB_ADDR_RST;
         wdata_q <= `EMB_DATA_RST;
         bus_cycle_strobe_n_prev_q <= 1'b1;
         dma_rd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bus_cycle_strobe_n_prev_q <= bus_cycle_strobe_n_in_s;
         dma_rd_q <= dma_rd_w;
         if (take_req && state_q == emb_pkg::EMB_ST_IDLE) begin
            wr_q <= core_write;
            space_q <= core_space;
            addr_q <= core_addr;
            wdata_q <= core_wdata;
         end
      end
   end

   // Core answer
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         core_done <= 1'b0;
         core_rdata <= `EMB_DATA_RST;
      end else begin
         core_done <= in_cycle && ready_s;
         if (in_cycle && ready_s && !wr_q) begin
            core_rdata <= data_in_s;
         end
      end
   end

   // Pin outputs
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         ext_addr_bus_out <= `EMB_ADDR_RST;
         ext_addr_bus_oe <= 1'b0;
         ext_data_bus_out <= `EMB_DATA_RST;
         ext_data_bus_oe <= 1'b0;
         data_space_sel_n <= `EMB_SEL_IDLE;
         program_space_sel_n <= `EMB_SEL_IDLE;
         io_space_sel_n <= `EMB_SEL_IDLE;
         space_sel_oe <= 1'b0;
         bus_cycle_strobe_n_out <= 1'b1;
         bus_cycle_strobe_n_oe <= 1'b0;
         rd_wr_n_out <= 1'b1;
         rd_wr_n_oe <= 1'b0;
         read_sel_n <= 1'b1;
         read_sel_oe <= 1'b0;
         bus_hold_ack_n <= 1'b1;
         bus_hold_ack_oe <= 1'b0;
      end else begin
         ext_addr_bus_out <= addr_q;
         ext_addr_bus_oe <= drive_addr;
         ext_data_bus_out <= dma_rd_q ? dma_ram_rdata : wdata_q;
         ext_data_bus_oe <= drive_data;
         data_space_sel_n <= !(sel_act && space_q == emb_pkg::EMB_SP_DATA);
         program_space_sel_n <= !(sel_act &&
                                  space_q == emb_pkg::EMB_SP_PROG);
         io_space_sel_n <= !(sel_act && space_q == emb_pkg::EMB_SP_IO);
         space_sel_oe <= !float_w;
         bus_cycle_strobe_n_out <= !in_cycle;
         bus_cycle_strobe_n_oe <= !float_w;
         rd_wr_n_out <= !(sel_act && wr_q);
         rd_wr_n_oe <= !float_w;
         read_sel_n <= !(in_cycle && !wr_q);
         read_sel_oe <= !float_w;
         bus_hold_ack_n <= !in_hold;
         bus_hold_ack_oe <= off_s;
      end
   end

   // Grant and on-chip RAM port
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         dma_grant <= 1'b0;
         dma_ram_en <= 1'b0;
         dma_ram_we <= 1'b0;
         dma_ram_addr <= `EMB_ADDR_RST;
         dma_ram_wdata <= `EMB_DATA_RST;
      end else begin
         dma_grant <= !br_s && ready_s;
         dma_ram_en <= dma_bus_cycle_strobe_n;
         dma_ram_we <= dma_bus_cycle_strobe_n && !rw_in_s;
         if (dma_bus_cycle_strobe_n) begin
            dma_ram_addr <= addr_in_s;
            dma_ram_wdata <= data_in_s;
         end
      end
   end

   // Checks
   sequence s_hold_seen;
      hold_s == 1'b0 && state_q == emb_pkg::EMB_ST_IDLE && off_s;
   endsequence
   sequence s_ack_low;
      ##2 bus_hold_ack_n == 1'b0 && bus_hold_ack_oe;
   endsequence

   a_addr_drive: assert property (@(posedge clk) disable iff (!rst_q)
      in_cycle && off_s |=> ext_addr_bus_oe &&
      ext_addr_bus_out == $past(addr_q))
      else $error("address not driven during bus cycle");
   a_addr_float: assert property (@(posedge clk) disable iff (!rst_q)
      !off_s |=> !ext_addr_bus_oe && !space_sel_oe)
      else $error("address driven while output-off low");
   a_dma_addr: assert property (@(posedge clk) disable iff (!rst_q)
      dma_bus_cycle_strobe_n |=> dma_ram_en && dma_ram_addr == $past(addr_in_s))
      else $error("DMA address not taken from pins");
   a_data_float: assert property (@(posedge clk) disable iff (!rst_q)
      (!rs_s || !off_s || (!wr_q && !dma_rd_q)) |=> !ext_data_bus_oe)
      else $error("data bus driven when it must float");
   a_dma_wdata: assert property (@(posedge clk) disable iff (!rst_q)
      dma_bus_cycle_strobe_n && !rw_in_s |=> dma_ram_we &&
      dma_ram_wdata == $past(data_in_s))
      else $error("DMA write data lost");
   a_space_idle: assert property (@(posedge clk) disable iff (!rst_q)
      state_q == emb_pkg::EMB_ST_IDLE |=> data_space_sel_n &&
      program_space_sel_n && io_space_sel_n)
      else $error("space select low outside an access");
   a_ready_wait: assert property (@(posedge clk) disable iff (!rst_q)
      in_cycle && !ready_s |=> in_cycle && !core_done)
      else $error("bus cycle ended without ready");
   a_grant_ready: assert property (@(posedge clk) disable iff (!rst_q)
      !br_s && ready_s |=> dma_grant)
      else $error("ready after bus request not granted");
   a_rw_read: assert property (@(posedge clk) disable iff (!rst_q)
      sel_act && !wr_q |=> rd_wr_n_out)
      else $error("direction low on a read");
   a_bus_cycle_strobe_n_cycle: assert property (@(posedge clk) disable iff (!rst_q)
      !bus_cycle_strobe_n_out |-> $past(in_cycle))
      else $error("strobe low outside a bus cycle");
   a_read_sel: assert property (@(posedge clk) disable iff (!rst_q)
      in_cycle && !wr_q |=> !read_sel_n ##1 $past(ready_s) || !read_sel_n)
      else $error("read select not low during read");
   a_hold_ack: assert property (@(posedge clk) disable iff (!rst_q)
      s_hold_seen |-> s_ack_low)
      else $error("hold not acknowledged in two cycles");
endmodule

// file: verif/emb_ext_mem.sv
// Memory and I/O device model on the far side of the external bus
module emb_ext_mem (
   // Clock
   input wire logic clk,
   // Bus from the block
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic strobe_n,
   input wire logic rd_wr_n,
   input wire logic rd_sel_n,
   input wire logic [3:0] wait_n,
   // Answer
   output logic ready,
   output logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0000;
   logic [3:0] cnt = 4'h0;
   initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
   // Ready rises after the chosen number of wait cycles
   assign ready = !strobe_n && cnt >= wait_n;
   always @(posedge clk) begin
      cnt <= strobe_n ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
      if (!strobe_n && !rd_wr_n && ready) mem[addr[3:0]] <= wdata;
      if (!rd_sel_n) last <= mem[addr[3:0]];
   end
   // Released data shows the inverse of the last word
   assign rdata = !rd_sel_n ? mem[addr[3:0]] : ~last;
endmodule

// file: verif/tb.sv
// Self-checking bench for the external bus interface
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, core_req = 1'b0, core_write = 1'b0;
   emb_pkg::emb_space_t core_space = emb_pkg::EMB_SP_DATA;
   logic [15:0] core_addr = 16'h0, core_wdata = 16'h0, dma_addr = 16'h0;
   logic [15:0] dma_wdata = 16'h0, dma_ram_rdata = 16'h0;
   logic hold_req_n = 1'b1, bus_request_n = 1'b1, instr_acquire_n = 1'b1;
   logic output_off_n = 1'b1, reset_in_n = 1'b1, bus_cycle_strobe_n_b = 1'b1, rw_b = 1'b1;
   logic [3:0] wait_n = 4'h0;
   logic core_done, ext_addr_bus_oe, ext_data_bus_oe, data_space_sel_n;
   logic program_space_sel_n, io_space_sel_n, space_sel_oe, read_sel_n;
   logic bus_cycle_strobe_n_out, bus_cycle_strobe_n_oe, rd_wr_n_out;
   logic rd_wr_n_oe, read_sel_oe, bus_hold_ack_n, bus_hold_ack_oe;
   logic dma_grant, dma_ram_en, dma_ram_we, bus_ready;
   logic [15:0] core_rdata, ext_addr_bus_out, ext_data_bus_out;
   logic [15:0] dma_ram_addr, dma_ram_wdata, mem_rdata;
   logic [15:0] ext_addr_bus_in, ext_data_bus_in;
   logic bus_cycle_strobe_n_in, rd_wr_n_in;
   logic [5:0] oes;
   int error_cnt = 0, n_compared = 0, cyc_cnt = 0;
   // Wire levels from all drivers
   assign ext_addr_bus_in = ext_addr_bus_oe ? ext_addr_bus_out : dma_addr;
   assign ext_data_bus_in = ext_data_bus_oe ? ext_data_bus_out :
      bus_hold_ack_n ? mem_rdata : dma_wdata;
   assign bus_cycle_strobe_n_in = bus_cycle_strobe_n_oe ?
      bus_cycle_strobe_n_out : bus_cycle_strobe_n_b;
   assign rd_wr_n_in = rd_wr_n_oe ? rd_wr_n_out : rw_b;
   assign oes = {ext_addr_bus_oe, ext_data_bus_oe, space_sel_oe,
      bus_cycle_strobe_n_oe, rd_wr_n_oe, read_sel_oe};
   always #12.5 clk = ~clk;
   emb_bus_if dut (.clk(clk), .rst_n(rst_n), .core_req(core_req),
      .core_write(core_write), .core_space(core_space),
      .core_addr(core_addr), .core_wdata(core_wdata),
      .core_done(core_done), .core_rdata(core_rdata),
      .ext_addr_bus_in(ext_addr_bus_in),
      .ext_addr_bus_out(ext_addr_bus_out),
      .ext_addr_bus_oe(ext_addr_bus_oe),
      .ext_data_bus_in(ext_data_bus_in),
      .ext_data_bus_out(ext_data_bus_out),
      .ext_data_bus_oe(ext_data_bus_oe),
      .data_space_sel_n(data_space_sel_n),
      .program_space_sel_n(program_space_sel_n),
      .io_space_sel_n(io_space_sel_n), .space_sel_oe(space_sel_oe),
      .bus_cycle_strobe_n_in(bus_cycle_strobe_n_in),
      .bus_cycle_strobe_n_out(bus_cycle_strobe_n_out),
      .bus_cycle_strobe_n_oe(bus_cycle_strobe_n_oe),
      .rd_wr_n_in(rd_wr_n_in), .rd_wr_n_out(rd_wr_n_out),
      .rd_wr_n_oe(rd_wr_n_oe), .read_sel_n(read_sel_n),
      .read_sel_oe(read_sel_oe), .bus_ready(bus_ready),
      .hold_req_n(hold_req_n), .bus_hold_ack_n(bus_hold_ack_n),
      .bus_hold_ack_oe(bus_hold_ack_oe), .bus_request_n(bus_request_n),
      .instr_acquire_n(instr_acquire_n), .output_off_n(output_off_n),
      .reset_in_n(reset_in_n), .dma_grant(dma_grant),
      .dma_ram_en(dma_ram_en), .dma_ram_we(dma_ram_we),
      .dma_ram_addr(dma_ram_addr), .dma_ram_wdata(dma_ram_wdata),
      .dma_ram_rdata(dma_ram_rdata));
   emb_ext_mem mem (.clk, .addr(ext_addr_bus_in), .wdata(ext_data_bus_in),
      .strobe_n(bus_cycle_strobe_n_in), .rd_wr_n(rd_wr_n_in),
      .rd_sel_n(read_sel_oe ? read_sel_n : 1'b1), .wait_n,
      .ready(bus_ready), .rdata(mem_rdata));
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic await(input string nm, ref logic s, input logic v);
      for (int n = 0; n < 40 && s !== v; n++) begin
         @(posedge clk);
         #1;
      end
      chk(nm, {15'h0, v}, {15'h0, s});
   endtask
   // One core access, with pins sampled while the strobe is low
   task automatic access(input emb_pkg::emb_space_t sp, input logic wr,
         input logic [15:0] a, d, output int cyc);
      logic [2:0] sel;
      logic rw, rs, doe;
      logic [15:0] ad, wd;
      @(posedge clk);
      core_req <= 1'b1;
      core_write <= wr;
      core_space <= sp;
      core_addr <= a;
      core_wdata <= d;
      for (cyc = 0; cyc < 60 && core_done !== 1'b1; cyc++) begin
         @(posedge clk);
         #1;
         if (bus_cycle_strobe_n_out === 1'b0) begin
            sel = {io_space_sel_n, program_space_sel_n, data_space_sel_n};
            {rw, rs, doe, ad, wd} = {rd_wr_n_out, read_sel_n,
               ext_data_bus_oe, ext_addr_bus_out, ext_data_bus_out};
         end
      end
      chk("done", 16'h1, {15'h0, core_done});
      chk("select", {13'h0, ~(3'h1 << sp)}, {13'h0, sel});
      chk("address", a, ad);
      chk("direction", {15'h0, !wr}, {15'h0, rw});
      chk("read select", {15'h0, wr}, {15'h0, rs});
      chk("data drive", {15'h0, wr}, {15'h0, doe});
      if (wr) chk("write data", d, wd);
      if (!wr) chk("read data", d, core_rdata);
      @(posedge clk);
      core_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("idle", 16'hf, {12'h0, bus_cycle_strobe_n_out, io_space_sel_n,
         program_space_sel_n, data_space_sel_n});
   endtask
   task automatic t_spaces();
      int c;
      for (int s = 0; s < 3; s++) begin
         access(emb_pkg::emb_space_t'(s), 1'b1, 16'h1230 + 16'(s),
            16'hc0d0 + 16'(s), c);
      end
      for (int s = 2; s >= 0; s--) begin
         access(emb_pkg::emb_space_t'(s), 1'b0, 16'h1230 + 16'(s),
            16'hc0d0 + 16'(s), c);
      end
   endtask
   task automatic t_wait();
      int c0, c5;
      access(emb_pkg::EMB_SP_IO, 1'b0, 16'h1232, 16'hc0d2, c0);
      wait_n = 4'h5;
      access(emb_pkg::EMB_SP_IO, 1'b0, 16'h1232, 16'hc0d2, c5);
      wait_n = 4'h0;
      chk("wait cycles", 16'h5, 16'(c5 - c0));
   endtask
   // Processor reset pin pulled low in the middle of a long write
   task automatic t_rs();
      wait_n = 4'hf;
      @(posedge clk);
      core_req <= 1'b1;
      core_write <= 1'b1;
      core_space <= emb_pkg::EMB_SP_DATA;
      core_addr <= 16'h1233;
      core_wdata <= 16'h3c5a;
      repeat (4) @(posedge clk);
      reset_in_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("data oe in reset", 16'h0, {15'h0, ext_data_bus_oe});
      @(posedge clk);
      reset_in_n <= 1'b1;
      await("data oe back", ext_data_bus_oe, 1'b1);
      await("done after reset", core_done, 1'b1);
      @(posedge clk);
      core_req <= 1'b0;
      wait_n = 4'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_hold_dma();
      @(posedge clk);
      hold_req_n <= 1'b0;
      await("hold ack", bus_hold_ack_n, 1'b0);
      chk("oe in hold", 16'h0, {10'h0, oes});
      chk("ack oe in hold", 16'h1, {15'h0, bus_hold_ack_oe});
      @(posedge clk);
      bus_request_n <= 1'b0;
      instr_acquire_n <= 1'b0;
      dma_addr <= 16'h0123;
      dma_wdata <= 16'hbeef;
      rw_b <= 1'b0;
      repeat (3) @(posedge clk);
      bus_cycle_strobe_n_b <= 1'b0;
      await("ram enable", dma_ram_en, 1'b1);
      chk("ram addr", 16'h0123, dma_ram_addr);
      chk("ram data", 16'hbeef, dma_ram_wdata);
      chk("ram write", 16'h1, {15'h0, dma_ram_we});
      @(posedge clk);
      bus_cycle_strobe_n_b <= 1'b1;
      rw_b <= 1'b1;
      dma_ram_rdata <= 16'h5a3c;
      repeat (3) @(posedge clk);
      bus_cycle_strobe_n_b <= 1'b0;
      await("dma drive", ext_data_bus_oe, 1'b1);
      await("grant", dma_grant, 1'b1);
      chk("dma read", 16'h5a3c, ext_data_bus_out);
      @(posedge clk);
      bus_cycle_strobe_n_b <= 1'b1;
      bus_request_n <= 1'b1;
      instr_acquire_n <= 1'b1;
      hold_req_n <= 1'b1;
      await("hold end", bus_hold_ack_n, 1'b1);
   endtask
   task automatic t_off();
      @(posedge clk);
      output_off_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk("oe when off", 16'h0, {10'h0, oes});
      chk("ack oe when off", 16'h0, {15'h0, bus_hold_ack_oe});
      @(posedge clk);
      output_off_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   initial begin
      repeat (15) @(posedge clk);
      #1;
      chk("oe in reset", 16'h0, {10'h0, oes});
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_spaces();
      t_wait();
      t_rs();
      t_hold_dma();
      t_off();
      t_spaces();
      summarize();
   end
endmodule
